//--- common/mbcad_defs.vh
`ifndef MBCAD_DEFS_VH
`define MBCAD_DEFS_VH

// ----------------------------------------------------------------
// Address direction codes
// ----------------------------------------------------------------
`define MBCAD_XY_ROW       2'b00
`define MBCAD_XY_ROW_COL   2'b01
`define MBCAD_XY_COL_ROW   2'b10
`define MBCAD_XY_COL       2'b11

// ----------------------------------------------------------------
// Clock mux styles
// ----------------------------------------------------------------
`define MBCAD_MUX_NONE     2'b00
`define MBCAD_MUX_SYNC     2'b01
`define MBCAD_MUX_GATED    2'b10
`define MBCAD_MUX_GLITCH   2'b11

// ----------------------------------------------------------------
// Test access port variants
// ----------------------------------------------------------------
`define MBCAD_TAP_BASIC    2'b00
`define MBCAD_TAP_PLAIN_IO 2'b01
`define MBCAD_TAP_WRAP     2'b10
`define MBCAD_TAP_BSCAN    2'b11

// External presentation codes
`define MBCAD_EXT_DIRECT   2'b00
`define MBCAD_EXT_BSCAN    2'b01
`define MBCAD_EXT_REDPIN   2'b10

// ----------------------------------------------------------------
// Wishbone register map (byte addresses)
// ----------------------------------------------------------------
`define MBCAD_ADR_CTRL     4'h0
`define MBCAD_ADR_STAT     4'h4
`define MBCAD_ADR_DIAG     4'h8
`define MBCAD_ADR_CFG      4'hc

// Control register fields
`define MBCAD_CTRL_START   0
`define MBCAD_CTRL_XY_LO   1
`define MBCAD_CTRL_XY_HI   2
`define MBCAD_CTRL_DIAG    3
`define MBCAD_CTRL_CLR     4

// Status register fields
`define MBCAD_ST_BUSY      0
`define MBCAD_ST_DONE      1
`define MBCAD_ST_FAIL      2
`define MBCAD_ST_COLPASS   3
`define MBCAD_ST_CKSEL     4

`define MBCAD_RST_XY       2'b00

`endif

//--- rtl/mbcad_top.v
// Added by the designer: the Wishbone register port and the register addresses.
`include "mbcad_defs.vh"

module mbcad_top
#(
	parameter ROW_W       = 4,
	parameter COL_W       = 2,
	parameter NUM_MEM     = 4,
	parameter MEM_ID_W    = 2,
	parameter TIME_W      = 16,
	parameter ADD_COL     = 1,
	parameter DUAL_CLK    = 1,
	parameter CLK_TRACE   = 0,
	parameter MUX_STYLE   = 2'b01,
	parameter DIAG_EN     = 1,
	parameter DIAG_SEQ_SH = 1,
	parameter DIAG_CTR_SH = 0,
	parameter TAP_KIND    = 2'b00
)
(
	// Clock and reset
	input  wire                   clk_i,
	input  wire                   rst_i,
	// Wishbone slave
	input  wire                   cyc_i,
	input  wire                   stb_i,
	input  wire                   we_i,
	input  wire [3:0]             adr_i,
	input  wire [3:0]             sel_i,
	input  wire [31:0]            dat_i,
	output reg  [31:0]            dat_o,
	output wire                   ack_o,
	// Test clocking
	input  wire                   mission_clock_i,
	input  wire                   tester_clock_i,
	input  wire                   clock_select_in_i,
	input  wire                   mux_bypass_port_i,
	output wire                   mem_clk_o,
	// Memory under test
	output reg  [ROW_W-1:0]       mem_row_o,
	output reg  [COL_W-1:0]       mem_col_o,
	output reg  [MEM_ID_W-1:0]    mem_id_o,
	output reg                    mem_en_o,
	input  wire [NUM_MEM-1:0]     mem_fail_i,
	// Access port presentation
	output wire [1:0]             ext_port_o
);

	// ------------------------------------------------------------
	// Configuration checks
	// ------------------------------------------------------------
	// Tracing and dual clocking may not coexist
	localparam DUAL_OK = (DUAL_CLK != 0) && (CLK_TRACE == 0);
	// Column passes need both the option and a real column field
	localparam COL_OK  = (ADD_COL != 0) && (COL_W > 0);
	localparam CTR_SH  = (DIAG_CTR_SH != 0) && (DIAG_SEQ_SH != 0);

	localparam S_IDLE = 4'b0001;
	localparam S_RUN  = 4'b0010;
	localparam S_NEXT = 4'b0100;
	localparam S_DONE = 4'b1000;

	localparam [ROW_W-1:0]    ROW_MAX = {ROW_W{1'b1}};
	localparam [COL_W-1:0]    COL_MAX = {COL_W{1'b1}};
	localparam integer        MEM_LAST = NUM_MEM - 1;
	localparam [MEM_ID_W-1:0] MEM_MAX = MEM_LAST[MEM_ID_W-1:0];

	// Access port presentation
	assign ext_port_o = (TAP_KIND == `MBCAD_TAP_BSCAN) ? `MBCAD_EXT_REDPIN :
		(TAP_KIND == `MBCAD_TAP_WRAP) ? `MBCAD_EXT_BSCAN :
		`MBCAD_EXT_DIRECT;

	// ------------------------------------------------------------
	// Clock selection
	// ------------------------------------------------------------
	reg  sel_s1_r;
	reg  sel_s2_r;
	reg  gf_a_r;
	reg  gf_b_r;
	wire sel_eff;

	// Without dual clocking the select input is ignored
	wire sel_raw = DUAL_OK ? clock_select_in_i : 1'b0;
	wire tclk    = DUAL_OK ? tester_clock_i : mission_clock_i;

	assign sel_eff = (MUX_STYLE == `MBCAD_MUX_SYNC) ? sel_s2_r : sel_raw;

	// Glitch-free: each side enables only after the other drops
	// (modelled on clk_i; a real cell runs on the muxed clocks)
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sel_s1_r <= 1'b0;
			sel_s2_r <= 1'b0;
			gf_a_r   <= 1'b0;
			gf_b_r   <= 1'b0;
		end
		else
		begin
			sel_s1_r <= sel_raw;
			sel_s2_r <= sel_s1_r;
			gf_a_r   <= ~sel_raw & ~gf_b_r;
			gf_b_r   <= sel_raw & ~gf_a_r;
		end
	end

	reg mclk;
	always @*
	begin
		case (MUX_STYLE)
			`MBCAD_MUX_GATED:
				// Gate then OR, one clock per leg
				mclk = (mission_clock_i & ~sel_raw) | (tclk & sel_raw);
			`MBCAD_MUX_GLITCH:
				if (mux_bypass_port_i)
					mclk = mission_clock_i;
				else
					mclk = (mission_clock_i & gf_a_r) | (tclk & gf_b_r);
			default:
				mclk = sel_eff ? tclk : mission_clock_i;
		endcase
	end
	assign mem_clk_o = mclk;

	// ------------------------------------------------------------
	// Wishbone registers
	// ------------------------------------------------------------
	reg  [1:0]           xy_r;
	reg                  diag_on_r;
	reg                  start_r;
	reg                  done_r;
	reg                  fail_r;
	reg  [TIME_W-1:0]    ftime_r;
	reg  [MEM_ID_W-1:0]  fmem_r;
	reg                  ack_r;
	reg  [3:0]           st_r;
	reg                  colpass_r;
	reg  [TIME_W-1:0]    tcnt_r;
	reg  [31:0]          rd_mux;

	assign ack_o = ack_r;
	// Writes land on the edge that samples ack high
	wire wr  = cyc_i & stb_i & we_i & ack_r & sel_i[0];
	wire clr = wr & (adr_i == `MBCAD_ADR_CTRL) & dat_i[`MBCAD_CTRL_CLR];

	always @*
	begin
		case (adr_i)
			`MBCAD_ADR_CTRL:
				rd_mux = {27'h0, 1'b0, diag_on_r, xy_r, 1'b0};
			`MBCAD_ADR_STAT:
				rd_mux = {27'h0, sel_eff, colpass_r, fail_r, done_r,
					~st_r[0]};
			`MBCAD_ADR_DIAG:
				rd_mux = {{(16-MEM_ID_W){1'b0}}, fmem_r,
					ftime_r[15:0]};
			`MBCAD_ADR_CFG:
				rd_mux = {24'h0, TAP_KIND[1:0], CTR_SH[0],
					DIAG_SEQ_SH[0], DIAG_EN[0], DUAL_OK[0],
					COL_OK[0], 1'b0};
			default:
				rd_mux = 32'h0;
		endcase
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			xy_r      <= `MBCAD_RST_XY;
			diag_on_r <= 1'b0;
			start_r   <= 1'b0;
			ack_r     <= 1'b0;
			dat_o     <= 32'h0;
		end
		else
		begin
			// One-cycle ack; read data frozen at the taking edge
			ack_r <= cyc_i & stb_i & ~ack_r;
			if (cyc_i & stb_i & ~ack_r)
				dat_o <= rd_mux;
			start_r <= wr & (adr_i == `MBCAD_ADR_CTRL)
				& dat_i[`MBCAD_CTRL_START] & st_r[0];
			// Config only changes while idle; the clock select is sampled in any state
			if (wr & (adr_i == `MBCAD_ADR_CTRL) & st_r[0])
			begin
				xy_r      <= dat_i[`MBCAD_CTRL_XY_HI:`MBCAD_CTRL_XY_LO];
				diag_on_r <= dat_i[`MBCAD_CTRL_DIAG] & (DIAG_EN != 0);
			end
		end
	end

	// ------------------------------------------------------------
	// Pass sequencer
	// ------------------------------------------------------------
	// Without column support every code collapses to a row pass
	function first_col;
		input [1:0] xy;
		begin
			first_col = COL_OK && (xy == `MBCAD_XY_COL ||
				xy == `MBCAD_XY_COL_ROW);
		end
	endfunction

	function two_pass;
		input [1:0] xy;
		begin
			two_pass = COL_OK && (xy == `MBCAD_XY_ROW_COL ||
				xy == `MBCAD_XY_COL_ROW);
		end
	endfunction

	reg  second_r;

	// Row pass: column is the fast index; column pass: row fast
	wire last_addr = (mem_row_o == ROW_MAX) & (mem_col_o == COL_MAX);
	wire last_mem  = (mem_id_o == MEM_MAX);

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_r      <= S_IDLE;
			colpass_r <= 1'b0;
			second_r  <= 1'b0;
			mem_row_o <= {ROW_W{1'b0}};
			mem_col_o <= {COL_W{1'b0}};
			mem_id_o  <= {MEM_ID_W{1'b0}};
			mem_en_o  <= 1'b0;
			tcnt_r    <= {TIME_W{1'b0}};
			done_r    <= 1'b0;
		end
		else
		begin
			case (st_r)
				S_IDLE:
				begin
					if (clr)
						done_r <= 1'b0;
					if (start_r)
					begin
						st_r      <= S_RUN;
						colpass_r <= first_col(xy_r);
						second_r  <= 1'b0;
						mem_row_o <= {ROW_W{1'b0}};
						mem_col_o <= {COL_W{1'b0}};
						mem_id_o  <= {MEM_ID_W{1'b0}};
						mem_en_o  <= 1'b1;
						tcnt_r    <= {TIME_W{1'b0}};
						done_r    <= 1'b0;
					end
				end
				S_RUN:
				begin
					tcnt_r <= tcnt_r + 1'b1;
					if (last_addr)
					begin
						mem_en_o <= 1'b0;
						st_r     <= S_NEXT;
					end
					else if (colpass_r)
					begin
						// Column pass: step rows inside a column
						mem_row_o <= mem_row_o + 1'b1;
						if (mem_row_o == ROW_MAX)
							mem_col_o <= mem_col_o + 1'b1;
					end
					else
					begin
						mem_col_o <= mem_col_o + 1'b1;
						if (mem_col_o == COL_MAX)
							mem_row_o <= mem_row_o + 1'b1;
					end
				end
				S_NEXT:
				begin
					mem_row_o <= {ROW_W{1'b0}};
					mem_col_o <= {COL_W{1'b0}};
					if (two_pass(xy_r) & ~second_r)
					begin
						second_r  <= 1'b1;
						colpass_r <= ~colpass_r;
						mem_en_o  <= 1'b1;
						st_r      <= S_RUN;
					end
					else if (!last_mem)
					begin
						mem_id_o  <= mem_id_o + 1'b1;
						second_r  <= 1'b0;
						colpass_r <= first_col(xy_r);
						mem_en_o  <= 1'b1;
						st_r      <= S_RUN;
					end
					else
						st_r <= S_DONE;
				end
				S_DONE:
				begin
					done_r <= 1'b1;
					st_r   <= S_IDLE;
				end
				default:
					st_r <= S_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Diagnosis capture
	// ------------------------------------------------------------
	// One shared store holds the first failure of all memories;
	// a per-memory store would cost NUM_MEM times the area
	reg  [MEM_ID_W-1:0] fail_idx;
	integer k;

	always @*
	begin
		fail_idx = {MEM_ID_W{1'b0}};
		for (k = NUM_MEM - 1; k >= 0; k = k - 1)
			if (mem_fail_i[k])
				fail_idx = k[MEM_ID_W-1:0];
	end

	wire any_fail = mem_en_o & st_r[1] & (|mem_fail_i);

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			fail_r  <= 1'b0;
			ftime_r <= {TIME_W{1'b0}};
			fmem_r  <= {MEM_ID_W{1'b0}};
		end
		else if (any_fail & ~fail_r)
		begin
			// Capture wins over a clear in the same cycle
			fail_r <= 1'b1;
			if (diag_on_r)
			begin
				ftime_r <= tcnt_r;
				fmem_r  <= fail_idx;
			end
		end
		else if (clr | start_r)
			fail_r <= 1'b0;
	end

endmodule

//--- verification/mbcad_checker.sv
module mbcad_checker
#(
	parameter ROW_W = 4,
	parameter COL_W = 2,
	parameter TAP_KIND = 2'b00
)
(
	// Clock and bus
	input wire logic	clk_i,
	input wire logic	rst_i,
	input wire logic	cyc_i,
	input wire logic	stb_i,
	input wire logic	we_i,
	input wire logic [3:0]	adr_i,
	input wire logic [31:0]	dat_i,
	input wire logic	ack_o,
	// Clocking and memory side
	input wire logic	mission_clock_i,
	input wire logic	tester_clock_i,
	input wire logic	clock_select_in_i,
	input wire logic	mem_clk_o,
	input wire logic [ROW_W-1:0]	mem_row_o,
	input wire logic [COL_W-1:0]	mem_col_o,
	input wire logic	mem_en_o,
	input wire logic [1:0]	ext_port_o
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int NADR = 1 << (ROW_W + COL_W);
	logic [1:0]	xy_r;
	logic	par_r;
	logic	s1_r;
	logic	s2_r;
	logic [15:0]	run_r;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ----------------------------------------------------------------
	// Helper state
	// ----------------------------------------------------------------
	// Writes while walking are refused, so only idle starts count
	always @(posedge clk_i)
	begin
		s1_r <= clock_select_in_i;
		s2_r <= s1_r;
		run_r <= mem_en_o ? run_r + 16'h1 : 16'h0;
		if ($fell(mem_en_o))
			par_r <= ~par_r;
		if (cyc_i && stb_i && we_i && ack_o && adr_i == 4'h0 && dat_i[0]
			&& !mem_en_o)
		begin
			xy_r <= dat_i[2:1];
			par_r <= 1'b0;
		end
		if (rst_i)
		begin
			{s1_r, s2_r, par_r, xy_r, run_r} <= '0;
		end
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	AST_ACK_RESP: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("Bus request not acked next cycle");
	AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
		else $error("Ack longer than one cycle");
	AST_RST_IDLE: assert property ($fell(rst_i) |-> !ack_o && !mem_en_o)
		else $error("Outputs busy right after reset");
	AST_ROW_ONLY: assert property (
		mem_en_o && $past(mem_en_o) && xy_r == 2'b00
		|-> mem_col_o == COL_W'($past(mem_col_o) + 1'b1))
		else $error("Row-only walk did not step column fastest");
	AST_COL_ONLY: assert property (
		mem_en_o && $past(mem_en_o) && xy_r == 2'b11
		|-> mem_row_o == ROW_W'($past(mem_row_o) + 1'b1))
		else $error("Column-only walk did not step row fastest");
	AST_TWO_ROW: assert property (
		mem_en_o && $past(mem_en_o) && ^xy_r && par_r == xy_r[1]
		|-> mem_col_o == COL_W'($past(mem_col_o) + 1'b1))
		else $error("Row pass out of order");
	AST_TWO_COL: assert property (
		mem_en_o && $past(mem_en_o) && ^xy_r && par_r != xy_r[1]
		|-> mem_row_o == ROW_W'($past(mem_row_o) + 1'b1))
		else $error("Column pass out of order");
	AST_PASS_LEN: assert property ($fell(mem_en_o) |-> run_r == NADR)
		else $error("Pass length wrong");
	AST_CLK_MUX: assert property (
		mem_clk_o == (s2_r ? tester_clock_i : mission_clock_i))
		else $error("Memory clock not from synced select");
	AST_EXT_PORT: assert property (
		ext_port_o == (TAP_KIND == 3 ? 2'b10 : TAP_KIND == 2 ? 2'b01 : 2'b00))
		else $error("Access port presentation wrong");
	cover property (xy_r == 2'b01 && $fell(mem_en_o));
	cover property ($rose(s2_r));
	cover property (ack_o && we_i);
endmodule

bind mbcad_top mbcad_checker #(.ROW_W(ROW_W), .COL_W(COL_W),
	.TAP_KIND(TAP_KIND)) u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
	.adr_i, .dat_i, .ack_o, .mission_clock_i, .tester_clock_i,
	.clock_select_in_i, .mem_clk_o, .mem_row_o, .mem_col_o, .mem_en_o,
	.ext_port_o);

//--- verification/mbcad_mem_model.sv
module mbcad_mem_model
#(
	parameter ROW_W = 4,
	parameter COL_W = 2,
	parameter NUM_MEM = 4
)
(
	// Address walk from the self-test
	input wire logic [ROW_W-1:0]	mem_row_i,
	input wire logic [COL_W-1:0]	mem_col_i,
	input wire logic [1:0]	mem_id_i,
	input wire logic	mem_en_i,
	// Fault injection
	input wire logic	bad_on_i,
	input wire logic [1:0]	bad_id_i,
	output wire logic [NUM_MEM-1:0]	fail_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// One stuck cell mid-array, so a flag needs a real address match
	wire hit = bad_on_i && mem_en_i && mem_id_i == bad_id_i
		&& mem_row_i == ROW_W'(3) && mem_col_i == COL_W'(1);
	assign fail_o = NUM_MEM'(hit) << bad_id_i;
endmodule

//--- verification/mbist_clock_address_diag_test.sv
`include "mbcad_defs.vh"
module mbist_clock_address_diag_test;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [1:0] xy; logic bad; logic [1:0] id;} mbcad_row_t;
	logic	clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [3:0]	adr_i = 4'h0, sel_i = 4'hf;
	logic [31:0]	dat_i = 32'h0, q;
	logic	mission_clock_i = 0, tester_clock_i = 0, tdiv_r = 0;
	logic	clock_select_in_i = 0, mux_bypass_port_i = 0, bad_on = 0;
	logic [1:0]	bad_id = 2'h0;
	wire [31:0]	dat_o;
	wire	ack_o, mem_clk_o, mem_en_o;
	wire [3:0]	mem_row_o, mem_fail_i;
	wire [1:0]	mem_col_o, mem_id_o, ext_port_o;
	int	miscompares = 0, checks_done = 0;
	// Fields: xy, inject, failing memory
	mbcad_row_t rows[4] = '{5'h00, 5'h0e, 5'h10, 5'h1d};
	mbcad_top DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
		.dat_i, .dat_o, .ack_o, .mission_clock_i, .tester_clock_i,
		.clock_select_in_i, .mux_bypass_port_i, .mem_clk_o, .mem_row_o,
		.mem_col_o, .mem_id_o, .mem_en_o, .mem_fail_i, .ext_port_o);
	mbcad_mem_model u_mem (.mem_row_i(mem_row_o), .mem_col_i(mem_col_o),
		.mem_id_i(mem_id_o), .mem_en_i(mem_en_o), .bad_on_i(bad_on),
		.bad_id_i(bad_id), .fail_o(mem_fail_i));
	always #50 clk_i = ~clk_i;
	// Two slow clocks of different rates so the mux source is visible
	always @(posedge clk_i)
	begin
		mission_clock_i <= ~mission_clock_i;
		tdiv_r <= ~tdiv_r;
		if (tdiv_r)
			tester_clock_i <= ~tester_clock_i;
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Fault cell row 3, column 1: index 13 row-first, 19 column-first
	function automatic int ftime_exp(input mbcad_row_t r);
		return r.id * ((r.xy == 2'b01 || r.xy == 2'b10) ? 128 : 64)
			+ (r.xy[1] ? 19 : 13);
	endfunction
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		{cyc_i, stb_i, we_i} <= 3'h0;
	endtask
	task automatic start(input logic [1:0] xy, input logic dg);
		wb(1'b1, `MBCAD_ADR_CTRL, 32'h10);
		wb(1'b1, `MBCAD_ADR_CTRL, {28'h0, dg, xy, 1'b1});
	endtask
	task automatic wait_idle;
		do wb(1'b0, `MBCAD_ADR_STAT, 32'h0); while (q[0] !== 1'b0);
	endtask
	initial
	begin
		repeat (30000) @(posedge clk_i);
		miscompares++;
		complete_run;
	end
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, `MBCAD_ADR_STAT, 32'h0);
		chk("stat_reset", q & 32'h1f, 32'h0);
		wb(1'b0, `MBCAD_ADR_CFG, 32'h0);
		chk("cfg", q & 32'hfe, 32'h1e);
		wb(1'b0, 4'h2, 32'h0);
		chk("unmapped", q, 32'h0);
		$display("test reset done");
		foreach (rows[i])
		begin
			bad_on <= rows[i].bad;
			bad_id <= rows[i].id;
			start(rows[i].xy, 1'b1);
			wait_idle;
			chk("done_fail", q[2:1], {rows[i].bad, 1'b1});
			wb(1'b0, `MBCAD_ADR_DIAG, 32'h0);
			if (rows[i].bad)
			begin
				chk("diag_mem", q[17:16], rows[i].id);
				chk("diag_time", q[15:0], ftime_exp(rows[i]));
			end
			$display("test row %0d done", i);
		end
		clock_select_in_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		wb(1'b0, `MBCAD_ADR_STAT, 32'h0);
		chk("sel_sync", q[4], 1'b1);
		start(2'b00, 1'b1);
		wait_idle;
		clock_select_in_i <= 1'b0;
		$display("test select done");
		start(2'b11, 1'b1);
		while (mem_en_o !== 1'b1) @(posedge clk_i);
		wb(1'b1, `MBCAD_ADR_CTRL, 32'h1);
		wb(1'b0, `MBCAD_ADR_STAT, 32'h0);
		chk("busy_col", q & 32'h9, 32'h9);
		wait_idle;
		$display("test refuse done");
		bad_on <= 1'b1;
		bad_id <= 2'h3;
		start(2'b00, 1'b0);
		wait_idle;
		chk("fail_nodiag", q[2], 1'b1);
		start(2'b01, 1'b1);
		while (mem_en_o !== 1'b1) @(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, `MBCAD_ADR_STAT, 32'h0);
		chk("stat_midrst", q[2:0], 3'h0);
		$display("test midreset done");
		complete_run;
	end
endmodule
